// ### hw/eef_top.v
// Behaviour
// - Transmit-done flag sets when transmit request falls, for any cause.
// - Success is done flag set, request not cancelled, abort status clear.
// - Transmit-done flag stays set until firmware clears it or reset.
// - Transmit-done raises interrupt only with its enable and ethernet enable.
// - Link-change flag cannot set until both PHY enables are set.
// - Link-change flag mirrors PHY global flag while both PHY enables are set; global always equals link flag.
// - Link interrupt needs link enable, both PHY enables and ethernet enable.
// - Link flag read-only; reading PHY request register clears all three flags.
// - Copy-done flag sets when copy start bit falls on completion.
// - Copy-done flag also sets when firmware cancels by clearing start bit.
// - Copy-done clears only by firmware or reset; enabled it interrupts.
// - Packet-pending flag is high whenever packet count is non-zero.
// - With packet and global enables, interrupt on each stored packet.
// - Packet-pending not writable; clears when count decremented to zero.
// - Memory from ring start through ring end belongs to receive hardware.
// - Writing ring start or end reloads write pointer with ring start.
// - Receive data is stored at the write pointer address.
// - Memory outside the ring is transmit buffer space.
// - After each packet a seven-byte status vector follows its last byte.
// - Transmit error flag setting also sets transmit-done in same cycle.
// - Abort clears transmit request, sets abort status, no retry.
`timescale 1ns/1ps
`include "eef_defines.vh"

module eef_top (
    // Clock and reset
    input  wire                    clk,
    input  wire                    arst_n,
    // Register port
    input  wire [7:0]              bus_addr,
    input  wire [`EEF_DW-1:0]      bus_wdata,
    input  wire                    bus_we,
    input  wire                    bus_re,
    output reg  [`EEF_DW-1:0]      bus_rdata,
    // Transmit engine
    input  wire                    tx_complete,
    input  wire                    tx_abort,
    input  wire [`EEF_SV_W-1:0]    tx_status_vec,
    output wire                    transmit_request,
    // Copy engine
    input  wire                    copy_finish,
    output wire                    copy_engine_start,
    // Receive path
    input  wire                    rx_byte_valid,
    input  wire [`EEF_DW-1:0]      rx_byte,
    input  wire                    rx_packet_done,
    output wire [`EEF_AW-1:0]      rx_read_pointer,
    // Link pin from the PHY, asynchronous
    input  wire                    link_pin,
    // Buffer memory write ports
    output reg                     rx_mem_we,
    output reg  [`EEF_AW-1:0]      rx_mem_addr,
    output reg  [`EEF_DW-1:0]      rx_mem_wdata,
    output reg                     sv_mem_we,
    output reg  [`EEF_AW-1:0]      sv_mem_addr,
    output reg  [`EEF_DW-1:0]      sv_mem_wdata,
    // Interrupt
    output reg                     eth_irq
);

    // ****************************************************************
    // Helpers
    // ****************************************************************
    function [`EEF_AW-1:0] ring_next;
        input [`EEF_AW-1:0] p;
        input [`EEF_AW-1:0] s;
        input [`EEF_AW-1:0] e;
        begin
            if (p == e) begin
                ring_next = s;
            end else begin
                ring_next = p + {{(`EEF_AW-1){1'b0}}, 1'b1};
            end
        end
    endfunction

    function in_ring;
        input [`EEF_AW-1:0] a;
        input [`EEF_AW-1:0] s;
        input [`EEF_AW-1:0] e;
        begin
            in_ring = (a >= s) && (a <= e);
        end
    endfunction

    function wr_at;
        input [7:0] off;
        begin
            wr_at = bus_we && (bus_addr == off);
        end
    endfunction

    // ****************************************************************
    // State
    // ****************************************************************
    reg                  tx_req_q;
    reg                  copy_go_q;
    reg                  tx_err_q;
    reg                  tx_abort_st_q;
    reg                  sv_hit_q;
    reg  [`EEF_DW-1:0]   enable_q;
    reg                  phy_link_ie_q;
    reg                  phy_global_ie_q;
    reg                  phy_link_flag_q;
    reg  [`EEF_DW-1:0]   pkt_cnt_q;
    reg  [`EEF_AW-1:0]   rx_start_q;
    reg  [`EEF_AW-1:0]   rx_end_q;
    reg  [`EEF_AW-1:0]   rx_wp_q;
    reg  [`EEF_AW-1:0]   rx_rp_q;
    reg  [`EEF_DW-1:0]   rx_rp_low_hold_q;
    reg  [`EEF_AW-1:0]   tx_end_q;
    reg                  link_s1_q;
    reg                  link_s2_q;
    reg                  link_s3_q;
    reg                  sv_busy_q;
    reg  [`EEF_SV_CNT_W-1:0] sv_cnt_q;
    reg  [`EEF_SV_W-1:0] sv_shift_q;
    reg  [`EEF_AW-1:0]   sv_addr_q;

    wire                 tx_done_flag;
    wire                 copy_done_flag;
    wire                 phy_both_en;
    wire                 phy_global_flag;
    wire                 link_change_flag;
    wire                 packet_pending_flag;
    wire                 tx_end_evt;
    wire                 phy_ir_read;
    wire                 link_change_evt;
    wire [`EEF_DW-1:0]   flags_rd;
    wire [`EEF_AW-1:0]   rx_start_d;
    wire [`EEF_AW-1:0]   rx_end_d;
    wire                 ring_write;
    wire                 pkt_dec;

    assign transmit_request  = tx_req_q;
    assign copy_engine_start = copy_go_q;
    assign rx_read_pointer   = rx_rp_q;

    // ****************************************************************
    // Transmit request, abort and error
    // ****************************************************************
    assign tx_end_evt = tx_req_q & (tx_complete | tx_abort);

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            tx_req_q      <= 1'b0;
            tx_err_q      <= 1'b0;
            tx_abort_st_q <= 1'b0;
        end else begin
            if (tx_end_evt) begin
                tx_req_q <= 1'b0;
            end else if (wr_at(`EEF_REG_CTRL)) begin
                tx_req_q <= bus_wdata[`EEF_CTRL_TX_REQ];
            end
            // Hardware set wins over firmware clear
            if (tx_req_q & tx_abort) begin
                tx_err_q <= 1'b1;
            end else if (wr_at(`EEF_REG_FLAGS) && bus_wdata[`EEF_FLG_TXERR]) begin
                tx_err_q <= 1'b0;
            end
            if (tx_req_q & tx_abort) begin
                tx_abort_st_q <= 1'b1;
            end else if (wr_at(`EEF_REG_STATUS) && bus_wdata[`EEF_ST_ABORT]) begin
                tx_abort_st_q <= 1'b0;
            end
        end
    end

    // Set on any fall of the request; the abort event sets it in the same
    // cycle as the error flag rather than one cycle later.
    eef_fall_flag u_tx_done (
        .clk       (clk),
        .arst_n    (arst_n),
        .level     (tx_req_q),
        .set_extra (tx_req_q & tx_abort),
        .clr       (wr_at(`EEF_REG_FLAGS) && bus_wdata[`EEF_FLG_TXDONE]),
        .flag_q    (tx_done_flag)
    );

    // ****************************************************************
    // Copy engine start and done
    // ****************************************************************
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            copy_go_q <= 1'b0;
        end else if (copy_go_q & copy_finish) begin
            copy_go_q <= 1'b0;
        end else if (wr_at(`EEF_REG_CTRL)) begin
            copy_go_q <= bus_wdata[`EEF_CTRL_COPY_GO];
        end
    end

    eef_fall_flag u_copy_done (
        .clk       (clk),
        .arst_n    (arst_n),
        .level     (copy_go_q),
        .set_extra (1'b0),
        .clr       (wr_at(`EEF_REG_FLAGS) && bus_wdata[`EEF_FLG_COPY]),
        .flag_q    (copy_done_flag)
    );

    // ****************************************************************
    // Link change through the PHY flags
    // ****************************************************************
    // Only the second stage and later feed the change detector
    assign link_change_evt = link_s2_q ^ link_s3_q;
    assign phy_both_en     = phy_link_ie_q & phy_global_ie_q;
    assign phy_ir_read     = bus_re && (bus_addr == `EEF_REG_PHY_IR);
    assign phy_global_flag = phy_link_flag_q;
    assign link_change_flag = phy_global_flag & phy_both_en;

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            link_s1_q       <= 1'b0;
            link_s2_q       <= 1'b0;
            link_s3_q       <= 1'b0;
            phy_link_ie_q   <= 1'b0;
            phy_global_ie_q <= 1'b0;
            phy_link_flag_q <= 1'b0;
        end else begin
            link_s1_q <= link_pin;
            link_s2_q <= link_s1_q;
            link_s3_q <= link_s2_q;
            if (wr_at(`EEF_REG_PHY_IE)) begin
                phy_link_ie_q   <= bus_wdata[`EEF_PHY_LINK];
                phy_global_ie_q <= bus_wdata[`EEF_PHY_GLOBAL];
            end
            if (link_change_evt & phy_both_en) begin
                phy_link_flag_q <= 1'b1;
            end else if (phy_ir_read) begin
                phy_link_flag_q <= 1'b0;
            end
        end
    end

    // ****************************************************************
    // Packet count and pending flag
    // ****************************************************************
    assign pkt_dec             = wr_at(`EEF_REG_PKT_DEC) && (pkt_cnt_q != `EEF_RST_BYTE);
    assign packet_pending_flag = (pkt_cnt_q != `EEF_RST_BYTE);

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pkt_cnt_q <= `EEF_RST_BYTE;
        end else begin
            // Count saturates; the receive side is expected to drop the packet at the limit
            if (rx_packet_done && !pkt_dec && pkt_cnt_q != `EEF_PKT_MAX) begin
                pkt_cnt_q <= pkt_cnt_q + 8'h01;
            end else if (pkt_dec && !rx_packet_done) begin
                pkt_cnt_q <= pkt_cnt_q - 8'h01;
            end
        end
    end

    // ****************************************************************
    // Receive ring pointers
    // ****************************************************************
    assign rx_start_d = wr_at(`EEF_REG_RXST_L) ? {rx_start_q[`EEF_AW-1:`EEF_DW], bus_wdata} :
                        wr_at(`EEF_REG_RXST_H) ? {bus_wdata[`EEF_HI_W-1:0], rx_start_q[`EEF_DW-1:0]} :
                        rx_start_q;
    assign rx_end_d   = wr_at(`EEF_REG_RXND_L) ? {rx_end_q[`EEF_AW-1:`EEF_DW], bus_wdata} :
                        wr_at(`EEF_REG_RXND_H) ? {bus_wdata[`EEF_HI_W-1:0], rx_end_q[`EEF_DW-1:0]} :
                        rx_end_q;
    assign ring_write = wr_at(`EEF_REG_RXST_L) | wr_at(`EEF_REG_RXST_H) |
                        wr_at(`EEF_REG_RXND_L) | wr_at(`EEF_REG_RXND_H);

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rx_start_q       <= `EEF_RST_PTR;
            rx_end_q         <= `EEF_RST_PTR;
            rx_wp_q          <= `EEF_RST_PTR;
            rx_rp_q          <= `EEF_RST_PTR;
            rx_rp_low_hold_q <= `EEF_RST_BYTE;
            rx_mem_we        <= 1'b0;
            rx_mem_addr      <= `EEF_RST_PTR;
            rx_mem_wdata     <= `EEF_RST_BYTE;
        end else begin
            rx_start_q <= rx_start_d;
            rx_end_q   <= rx_end_d;
            rx_mem_we  <= rx_byte_valid;
            if (rx_byte_valid) begin
                rx_mem_addr  <= rx_wp_q;
                rx_mem_wdata <= rx_byte;
            end
            if (ring_write) begin
                rx_wp_q <= rx_start_d;
            end else if (rx_byte_valid) begin
                rx_wp_q <= ring_next(rx_wp_q, rx_start_q, rx_end_q);
            end
            // Low byte waits until the high byte arrives, so the pointer never tears
            if (wr_at(`EEF_REG_RXRP_L)) begin
                rx_rp_low_hold_q <= bus_wdata;
            end
            if (wr_at(`EEF_REG_RXRP_H)) begin
                rx_rp_q <= {bus_wdata[`EEF_HI_W-1:0], rx_rp_low_hold_q};
            end
        end
    end

    // ****************************************************************
    // Transmit status vector writer
    // ****************************************************************
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            tx_end_q     <= `EEF_RST_PTR;
            sv_busy_q    <= 1'b0;
            sv_cnt_q     <= `EEF_RST_CNT;
            sv_shift_q   <= `EEF_RST_SV;
            sv_addr_q    <= `EEF_RST_PTR;
            sv_hit_q     <= 1'b0;
            sv_mem_we    <= 1'b0;
            sv_mem_addr  <= `EEF_RST_PTR;
            sv_mem_wdata <= `EEF_RST_BYTE;
        end else begin
            if (wr_at(`EEF_REG_TXND_L)) begin
                tx_end_q[`EEF_DW-1:0] <= bus_wdata;
            end
            if (wr_at(`EEF_REG_TXND_H)) begin
                tx_end_q[`EEF_AW-1:`EEF_DW] <= bus_wdata[`EEF_HI_W-1:0];
            end
            sv_mem_we <= sv_busy_q;
            if (sv_busy_q) begin
                sv_mem_addr  <= sv_addr_q;
                sv_mem_wdata <= sv_shift_q[`EEF_DW-1:0];
                sv_shift_q   <= sv_shift_q >> `EEF_DW;
                sv_addr_q    <= sv_addr_q + {{(`EEF_AW-1){1'b0}}, 1'b1};
                sv_cnt_q     <= sv_cnt_q - 3'h1;
                if (sv_cnt_q == 3'h1) begin
                    sv_busy_q <= 1'b0;
                end
            end else if (tx_end_evt) begin
                sv_busy_q  <= 1'b1;
                sv_cnt_q   <= `EEF_SV_BYTES;
                sv_shift_q <= tx_status_vec;
                sv_addr_q  <= tx_end_q + {{(`EEF_AW-1){1'b0}}, 1'b1};
            end
            // Flags a vector byte landing inside the ring; it is still written
            if (sv_busy_q && in_ring(sv_addr_q, rx_start_q, rx_end_q)) begin
                sv_hit_q <= 1'b1;
            end else if (wr_at(`EEF_REG_STATUS) && bus_wdata[`EEF_ST_SV_HIT]) begin
                sv_hit_q <= 1'b0;
            end
        end
    end

    // ****************************************************************
    // Interrupt
    // ****************************************************************
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            enable_q <= `EEF_RST_BYTE;
            eth_irq  <= 1'b0;
        end else begin
            if (wr_at(`EEF_REG_ENABLE)) begin
                enable_q <= bus_wdata;
            end
            eth_irq <= enable_q[`EEF_EN_ETH] & (
                       (tx_done_flag        & enable_q[`EEF_EN_TXDONE]) |
                       (tx_err_q            & enable_q[`EEF_EN_TXERR])  |
                       (link_change_flag    & enable_q[`EEF_EN_LINK])   |
                       (copy_done_flag      & enable_q[`EEF_EN_COPY])   |
                       (packet_pending_flag & enable_q[`EEF_EN_PKT]));
        end
    end

    // ****************************************************************
    // Register read
    // ****************************************************************
    assign flags_rd = {1'b0, packet_pending_flag, copy_done_flag, link_change_flag,
                       tx_done_flag, 1'b0, tx_err_q, 1'b0};

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            bus_rdata <= `EEF_RST_BYTE;
        end else if (bus_re) begin
            case (bus_addr)
                `EEF_REG_CTRL:    bus_rdata <= {6'h00, copy_go_q, tx_req_q};
                `EEF_REG_FLAGS:   bus_rdata <= flags_rd;
                `EEF_REG_ENABLE:  bus_rdata <= enable_q;
                `EEF_REG_STATUS:  bus_rdata <= {4'h0, sv_hit_q, link_s2_q, tx_abort_st_q, 1'b0};
                `EEF_REG_PHY_IE:  bus_rdata <= {3'h0, phy_link_ie_q, 2'h0, phy_global_ie_q, 1'b0};
                `EEF_REG_PHY_IR:  bus_rdata <= {3'h0, phy_link_flag_q, 1'b0, phy_global_flag, 2'h0};
                `EEF_REG_PKT_CNT: bus_rdata <= pkt_cnt_q;
                `EEF_REG_RXST_L:  bus_rdata <= rx_start_q[`EEF_DW-1:0];
                `EEF_REG_RXST_H:  bus_rdata <= {3'h0, rx_start_q[`EEF_AW-1:`EEF_DW]};
                `EEF_REG_RXND_L:  bus_rdata <= rx_end_q[`EEF_DW-1:0];
                `EEF_REG_RXND_H:  bus_rdata <= {3'h0, rx_end_q[`EEF_AW-1:`EEF_DW]};
                `EEF_REG_RXWP_L:  bus_rdata <= rx_wp_q[`EEF_DW-1:0];
                `EEF_REG_RXWP_H:  bus_rdata <= {3'h0, rx_wp_q[`EEF_AW-1:`EEF_DW]};
                `EEF_REG_RXRP_L:  bus_rdata <= rx_rp_q[`EEF_DW-1:0];
                `EEF_REG_RXRP_H:  bus_rdata <= {3'h0, rx_rp_q[`EEF_AW-1:`EEF_DW]};
                `EEF_REG_TXND_L:  bus_rdata <= tx_end_q[`EEF_DW-1:0];
                `EEF_REG_TXND_H:  bus_rdata <= {3'h0, tx_end_q[`EEF_AW-1:`EEF_DW]};
                default:          bus_rdata <= `EEF_RST_BYTE;
            endcase
        end
    end

endmodule // eef_top

// ### hw/eef_defines.vh
`ifndef EEF_DEFINES_VH
`define EEF_DEFINES_VH

// ****************************************************************
// Widths
// ****************************************************************
`define EEF_DW            8
`define EEF_AW            13
`define EEF_HI_W          5
`define EEF_SV_BYTES      3'h7
`define EEF_SV_W          56
`define EEF_SV_CNT_W      3
`define EEF_PKT_MAX       8'hFF

// ****************************************************************
// Register offsets
// ****************************************************************
`define EEF_REG_CTRL      8'h00
`define EEF_REG_FLAGS     8'h01
`define EEF_REG_ENABLE    8'h02
`define EEF_REG_STATUS    8'h03
`define EEF_REG_PHY_IE    8'h04
`define EEF_REG_PHY_IR    8'h05
`define EEF_REG_PKT_CNT   8'h06
`define EEF_REG_PKT_DEC   8'h07
`define EEF_REG_RXST_L    8'h08
`define EEF_REG_RXST_H    8'h09
`define EEF_REG_RXND_L    8'h0A
`define EEF_REG_RXND_H    8'h0B
`define EEF_REG_RXWP_L    8'h0C
`define EEF_REG_RXWP_H    8'h0D
`define EEF_REG_RXRP_L    8'h0E
`define EEF_REG_RXRP_H    8'h0F
`define EEF_REG_TXND_L    8'h10
`define EEF_REG_TXND_H    8'h11

// ****************************************************************
// Field positions
// ****************************************************************
`define EEF_CTRL_TX_REQ   0
`define EEF_CTRL_COPY_GO  1
`define EEF_FLG_TXERR     1
`define EEF_FLG_TXDONE    3
`define EEF_FLG_LINK      4
`define EEF_FLG_COPY      5
`define EEF_FLG_PKT       6
`define EEF_EN_TXERR      1
`define EEF_EN_TXDONE     3
`define EEF_EN_LINK       4
`define EEF_EN_COPY       5
`define EEF_EN_PKT        6
`define EEF_EN_ETH        7
`define EEF_ST_ABORT      1
`define EEF_ST_LINK       2
`define EEF_ST_SV_HIT     3
`define EEF_PHY_GLOBAL    1
`define EEF_PHY_FLAG_G    2
`define EEF_PHY_LINK      4

// ****************************************************************
// Reset values
// ****************************************************************
`define EEF_RST_BYTE      8'h00
`define EEF_RST_PTR       13'h0000
`define EEF_RST_SV        56'h00000000000000
`define EEF_RST_CNT       3'h0

`endif

// ### hw/eef_fall_flag.v
`timescale 1ns/1ps

// Sticky flag set by the falling edge of a control bit or by an extra event.
// A set arriving with the clear wins, so no event is lost.
module eef_fall_flag (
    // Clock and reset
    input  wire clk,
    input  wire arst_n,
    // Watched bit and events
    input  wire level,
    input  wire set_extra,
    input  wire clr,
    // Flag
    output reg  flag_q
);

    reg  level_q;
    wire fell;

    assign fell = level_q & ~level;

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            level_q <= 1'b0;
            flag_q  <= 1'b0;
        end else begin
            level_q <= level;
            if (fell | set_extra) begin
                flag_q <= 1'b1;
            end else if (clr) begin
                flag_q <= 1'b0;
            end
        end
    end

endmodule // eef_fall_flag

// ### sim/eef_top_properties.sv
`timescale 1ns/1ps
`include "eef_defines.vh"
module eef_props (
    // Clock and reset
    input wire                 clk,
    input wire                 arst_n,
    // Register port
    input wire [7:0]           bus_addr,
    input wire [`EEF_DW-1:0]   bus_wdata,
    input wire                 bus_we,
    input wire                 bus_re,
    input wire [`EEF_DW-1:0]   bus_rdata,
    // Engines and receive path
    input wire                 tx_complete,
    input wire                 tx_abort,
    input wire [`EEF_SV_W-1:0] tx_status_vec,
    input wire                 transmit_request,
    input wire                 copy_finish,
    input wire                 copy_engine_start,
    input wire                 rx_byte_valid,
    input wire [`EEF_DW-1:0]   rx_byte,
    input wire                 rx_packet_done,
    input wire [`EEF_AW-1:0]   rx_read_pointer,
    input wire                 link_pin,
    // Memory ports and interrupt
    input wire                 rx_mem_we,
    input wire [`EEF_AW-1:0]   rx_mem_addr,
    input wire [`EEF_DW-1:0]   rx_mem_wdata,
    input wire                 sv_mem_we,
    input wire [`EEF_AW-1:0]   sv_mem_addr,
    input wire [`EEF_DW-1:0]   sv_mem_wdata,
    input wire                 eth_irq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    property p_abort; tx_abort && transmit_request && !bus_we |=> !transmit_request; endproperty
    a_abort: assert property (p_abort) else $error("request still high after abort");
    property p_copy_end; copy_finish && copy_engine_start && !bus_we |=> !copy_engine_start; endproperty
    a_copy_end: assert property (p_copy_end) else $error("copy start still high after finish");
    property p_rx_store; rx_byte_valid |=> rx_mem_we && rx_mem_wdata == $past(rx_byte); endproperty
    a_rx_store: assert property (p_rx_store) else $error("received byte not stored");
    property p_sv_burst;
        tx_complete && transmit_request && !sv_mem_we |-> ##2 sv_mem_we [*7] ##1 !sv_mem_we;
    endproperty
    a_sv_burst: assert property (p_sv_burst) else $error("status vector is not seven bytes");
    property p_sv_addr; sv_mem_we && $past(sv_mem_we) |-> sv_mem_addr == $past(sv_mem_addr) + 13'h1; endproperty
    a_sv_addr: assert property (p_sv_addr) else $error("status vector bytes not consecutive");
    property p_phy_pair; bus_re && bus_addr == 8'h05 |=> bus_rdata[4] == bus_rdata[2]; endproperty
    a_phy_pair: assert property (p_phy_pair) else $error("phy global and link flags differ");
    property p_sticky;
        bus_re && bus_addr == 8'h01 ##1 bus_rdata[3] && !bus_we ##1 bus_re && bus_addr == 8'h01 |=> bus_rdata[3];
    endproperty
    a_sticky: assert property (p_sticky) else $error("transmit done cleared by itself");
    property p_pend;
        bus_re && bus_addr == 8'h06 && !rx_packet_done ##1 !rx_packet_done && !bus_we
        ##1 bus_re && bus_addr == 8'h01 && !rx_packet_done |=> bus_rdata[6] == ($past(bus_rdata, 2) != 8'h00);
    endproperty
    a_pend: assert property (p_pend) else $error("packet pending disagrees with count");
endmodule // eef_props
bind eef_top eef_props u_props (.*);

// ### sim/tb_ethernet_event_flags_buffer_setup.sv
`timescale 1ns/1ps
module tb_ethernet_event_flags_buffer_setup;
reg clk=0, arst_n=0, we=0, re=0, tc=0, ta=0, cf=0, rv=0, pd=0, lp=0;
reg  [7:0]  ad=0, wd=0, rb=0, v;
reg  [63:0] sv=0;
reg  [12:0] sa0, st;
wire [7:0]  rd, rmd, smd;
wire [12:0] rp, rma, sma;
wire        treq, cgo, rmw, smw, irq;
integer fails=0, num_checks=0, seed=32'h24e7, cnt=0, i, svn=0, r;
always #10 clk = ~clk;
eef_top dut (.clk(clk), .arst_n(arst_n), .bus_addr(ad), .bus_wdata(wd), .bus_we(we), .bus_re(re),
    .bus_rdata(rd), .tx_complete(tc), .tx_abort(ta), .tx_status_vec(sv[55:0]), .transmit_request(treq),
    .copy_finish(cf), .copy_engine_start(cgo), .rx_byte_valid(rv), .rx_byte(rb), .rx_packet_done(pd),
    .rx_read_pointer(rp), .link_pin(lp), .rx_mem_we(rmw), .rx_mem_addr(rma), .rx_mem_wdata(rmd),
    .sv_mem_we(smw), .sv_mem_addr(sma), .sv_mem_wdata(smd), .eth_irq(irq));
task automatic chk(input [79:0] n, input [15:0] s, e); begin
    num_checks = num_checks + 1;
    if (s !== e) begin fails = fails + 1; $display("[FAIL] %0s expected %h seen %h", n, e, s); end
end endtask
task wr(input [7:0] a, d); begin @(posedge clk); ad <= a; wd <= d; we <= 1; @(posedge clk); we <= 0; #1; end endtask
task rdr(input [7:0] a); begin @(posedge clk); ad <= a; re <= 1; @(posedge clk); re <= 0; #1 v = rd; end endtask
task complete_run; begin
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
end endtask
// Status vector bytes leave low byte first
always @(posedge clk) if (smw) begin
    if (svn == 0) sa0 <= sma;
    chk("sv_byte", smd, sv[(svn % 7) * 8 +: 8]);
    svn <= svn + 1;
end
initial begin repeat (20000) @(posedge clk); fails = fails + 1; complete_run; end
initial begin
    // ****************************************************************
    // Scenarios
    // ****************************************************************
    repeat (12) @(posedge clk);
    arst_n <= 1;
    sv <= {$random(seed), $random(seed)};
    wr(8'h10, 8'h40); wr(8'h11, 8'h00); wr(8'h02, 8'h88); wr(8'h00, 8'h01);
    @(posedge clk) tc <= 1; @(posedge clk) tc <= 0; repeat (12) @(posedge clk);
    chk("treq", treq, 0); rdr(1); chk("txdone", v[3], 1);
    rdr(1); chk("sticky", v[3], 1); chk("irq_tx", irq, 1);
    chk("sv_cnt", svn, 7); chk("sv_addr", sa0, 13'h41); rdr(3); chk("ok", v[1], 0);
    chk("sv_hit", v[3], 0);
    wr(8'h02, 8'h08); repeat (2) @(posedge clk); chk("irq_off", irq, 0);
    wr(8'h01, 8'h08); rdr(1); chk("tx_clr", v[3], 0);
    wr(0, 1); wr(0, 0); rdr(1); chk("cancel", v[3], 1); $display("transmit done");
    wr(8'h01, 8'h0A); wr(0, 1); @(posedge clk) ta <= 1; @(posedge clk) ta <= 0; repeat (12) @(posedge clk);
    rdr(1); chk("err_done", {v[3], v[1]}, 3); chk("treq_ab", treq, 0);
    rdr(3); chk("abrt", v[1], 1); $display("abort done");
    wr(8'h02, 8'hA0); wr(0, 2); @(posedge clk) cf <= 1; @(posedge clk) cf <= 0; repeat (3) @(posedge clk);
    chk("cgo", cgo, 0); rdr(1); chk("copy", v[5], 1); chk("irq_cp", irq, 1);
    wr(8'h01, 8'h20); wr(0, 2); wr(0, 0); rdr(1); chk("cp_cancel", v[5], 1);
    wr(8'h01, 8'h20); $display("copy done");
    wr(8'h02, 8'h90); @(posedge clk) lp <= 1; repeat (8) @(posedge clk); rdr(1); chk("link_off", v[4], 0);
    wr(8'h04, 8'h12); @(posedge clk) lp <= 0; repeat (8) @(posedge clk); rdr(1); chk("link", v[4], 1);
    chk("irq_ln", irq, 1); rdr(5); chk("phy", {v[4], v[2]}, 3);
    rdr(1); chk("link_clr", v[4], 0); $display("link done");
    wr(8'h02, 8'hC0);
    i = ($random(seed) & 7) + 1;
    repeat (i) begin
        @(posedge clk) pd <= 1; @(posedge clk) pd <= 0; cnt = cnt + 1;
    end
    wr(8'h01, 8'h40); rdr(6); chk("cnt", v, cnt); rdr(1); chk("pend", v[6], 1);
    repeat (2) @(posedge clk); chk("irq_pk", irq, 1);
    while (cnt > 0) begin wr(8'h07, 8'h00); cnt = cnt - 1; rdr(1); chk("pend_dec", v[6], cnt != 0); end
    repeat (2) @(posedge clk); chk("irq_pk0", irq, 0); $display("packets done");
    r = $random(seed); st = (r[12:0] & 13'h0FFE) | 13'h0100;
    wr(8'h08, st[7:0]); wr(8'h09, {3'h0, st[12:8]}); wr(8'h0A, 8'hFF); wr(8'h0B, 8'h1F);
    rdr(8'h0C); chk("wp_l", v, st[7:0]); rdr(8'h0D); chk("wp_h", v, st[12:8]);
    for (i = 0; i < 4; i = i + 1) begin
        r = $random(seed); @(posedge clk) rv <= 1; rb <= r[7:0]; @(posedge clk) rv <= 0; #1;
        chk("rx_addr", rma, st + i); chk("rx_data", rmd, rb);
    end
    wr(8'h0E, st[7:0]); chk("rp_held", rp, 0); wr(8'h0F, {3'h0, st[12:8]}); chk("rp", rp, st);
    $display("ring done");
    complete_run;
end
endmodule // tb_ethernet_event_flags_buffer_setup
